//--- pptc_pkg.sv
`default_nettype none
package pptc_pkg;
  // ----------------------------------------
  // configuration defaults
  // ----------------------------------------
  localparam logic DEF_PAUSE_ACK_WAIT = 1'b1;
  localparam logic DEF_FORWARD_CTRL = 1'b0;
  localparam logic [47:0] DEF_PAUSE_DA = 48'h0180_c200_0001;
  localparam logic [47:0] DEF_PAUSE_SA = 48'h0000_0000_0000;
  localparam logic [15:0] DEF_PAUSE_ETYPE = 16'h8808;
  localparam logic [15:0] DEF_GLOBAL_OPCODE = 16'h0001;
  localparam logic [15:0] DEF_PRIO_OPCODE = 16'h0101;
  localparam logic DEF_SINGLE_STEP = 1'b0;
  localparam logic DEF_TRANSP_CLK = 1'b0;
  localparam logic [10:0] DEF_LATENCY_ADJ = 11'h2c1;
  localparam int LAT_FRAC_BITS = 3;
  localparam int ACK_W = 9;
  localparam int TS_W = 80;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [47:0] dest_addr;
    logic [47:0] src_addr;
    logic [15:0] ethertype;
    logic [15:0] opcode;
  } pptc_pause_hdr_t;

  typedef struct packed {
    logic pause_ack_wait;
    logic forward_ctrl_frames;
    pptc_pause_hdr_t global_hdr;
    pptc_pause_hdr_t prio_hdr;
    logic single_step_ts_en;
    logic transparent_clk_mode;
    logic [10:0] ts_latency_adjust;
  } pptc_cfg_t;

  localparam pptc_cfg_t DEF_CFG = '{
    pause_ack_wait: DEF_PAUSE_ACK_WAIT,
    forward_ctrl_frames: DEF_FORWARD_CTRL,
    global_hdr: '{DEF_PAUSE_DA, DEF_PAUSE_SA, DEF_PAUSE_ETYPE, DEF_GLOBAL_OPCODE},
    prio_hdr: '{DEF_PAUSE_DA, DEF_PAUSE_SA, DEF_PAUSE_ETYPE, DEF_PRIO_OPCODE},
    single_step_ts_en: DEF_SINGLE_STEP,
    transparent_clk_mode: DEF_TRANSP_CLK,
    ts_latency_adjust: DEF_LATENCY_ADJ
  };
endpackage : pptc_pkg
`default_nettype wire

//--- pptc_config.sv
// What this block does
// - ack wait on: use nine-bit pause ack bus; off: ignore it
// - forward control frames when enabled; otherwise drop them (default drop)
// - global pause frames carry configured dest, ethertype, opcode
// - priority pause frames carry configured dest, ethertype, opcode
// - separate 48-bit source addresses for global and priority pause, default zero
// - single-step timestamping only when single_step_ts_en set
// - transparent mode: timer is correction; add tx stamp to correction field
// - single-step stamp offset by 11-bit adjust, bits 10:3 whole ns
`timescale 1ns/10ps
`default_nettype none
module pptc_config (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // static configuration from user
  input wire pptc_pkg::pptc_cfg_t cfg_in,
  // receive pause and control
  input wire logic [pptc_pkg::ACK_W-1:0] pause_ack_bus_in,
  input wire logic rx_ctrl_frame_in,
  output logic [pptc_pkg::ACK_W-1:0] pause_ack_used_out,
  output logic rx_ctrl_pass_out,
  // transmit pause header generation
  input wire logic tx_prio_sel_in,
  output pptc_pkg::pptc_pause_hdr_t pause_hdr_out,
  // transmit timestamp path
  input wire logic tx_ptp_pkt_in,
  input wire logic [pptc_pkg::TS_W-1:0] timer_in,
  input wire logic [63:0] corr_field_in,
  output logic [pptc_pkg::TS_W-1:0] single_step_ts_out,
  output logic single_step_ts_valid_out,
  output logic [63:0] corr_field_out,
  output logic corr_update_out
);
  // ----------------------------------------
  // configuration capture
  // ----------------------------------------
  // one settle cycle: a value is applied only after it was seen twice equal
  // costs a cycle of latency, but a setting moving across edges never lands half-made
  pptc_pkg::pptc_cfg_t cfg_reg;
  pptc_pkg::pptc_cfg_t cfg_seen_reg;
  logic cfg_live_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_seen_reg <= pptc_pkg::DEF_CFG;
      cfg_reg <= pptc_pkg::DEF_CFG;
      cfg_live_reg <= 1'b0;
    end else if (ce_in) begin
      cfg_seen_reg <= cfg_in;
      cfg_live_reg <= 1'b1;
      if (cfg_live_reg && cfg_seen_reg == cfg_in) begin
        cfg_reg <= cfg_in;
      end
    end
  end

  // ----------------------------------------
  // receive side
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pause_ack_used_out <= '0;
      rx_ctrl_pass_out <= 1'b0;
    end else if (ce_in) begin
      // ack wait off: bus ignored, acts as all acknowledged
      pause_ack_used_out <= cfg_reg.pause_ack_wait ? pause_ack_bus_in : '1;
      rx_ctrl_pass_out <= rx_ctrl_frame_in && cfg_reg.forward_ctrl_frames;
    end
  end

  // ----------------------------------------
  // pause header selection
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pause_hdr_out <= pptc_pkg::DEF_CFG.global_hdr;
    end else if (ce_in) begin
      pause_hdr_out <= tx_prio_sel_in ? cfg_reg.prio_hdr : cfg_reg.global_hdr;
    end
  end

  // ----------------------------------------
  // timestamp path
  // ----------------------------------------
  function automatic logic [pptc_pkg::TS_W-1:0] adj_ts(
    input logic [pptc_pkg::TS_W-1:0] ts, input logic [10:0] adj);
    // timer low bits hold fractional ns in the same three-bit scale
    adj_ts = ts + {{(pptc_pkg::TS_W-11){1'b0}}, adj};
  endfunction : adj_ts

  logic [pptc_pkg::TS_W-1:0] stamp;
  assign stamp = adj_ts(timer_in, cfg_reg.ts_latency_adjust);

  // gated strobes, shared by the flops and the checks below
  logic step_fire;
  logic corr_fire;
  assign step_fire = tx_ptp_pkt_in && cfg_reg.single_step_ts_en;
  assign corr_fire = tx_ptp_pkt_in && cfg_reg.transparent_clk_mode;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      single_step_ts_out <= '0;
      single_step_ts_valid_out <= 1'b0;
    end else if (ce_in) begin
      single_step_ts_valid_out <= step_fire;
      if (step_fire) begin
        single_step_ts_out <= stamp;
      end
    end
  end

  // correction relies on user pre-subtracting rx stamp and timer format
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      corr_field_out <= '0;
      corr_update_out <= 1'b0;
    end else if (ce_in) begin
      corr_update_out <= corr_fire;
      if (corr_fire) begin
        corr_field_out <= corr_field_in + stamp[63:0];
      end
    end
  end

  // ----------------------------------------
  // assertions: receive side
  // ----------------------------------------
  a_ack_ignored: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !cfg_reg.pause_ack_wait |=> pause_ack_used_out == '1)
    else $error("ack bus used while ack wait off");
  a_ack_passed: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && cfg_reg.pause_ack_wait |=> pause_ack_used_out == $past(pause_ack_bus_in))
    else $error("ack bus not passed");
  a_ctrl_drop: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !cfg_reg.forward_ctrl_frames |=> !rx_ctrl_pass_out)
    else $error("control frame forwarded while dropping");
  a_ctrl_fwd: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && cfg_reg.forward_ctrl_frames |=> rx_ctrl_pass_out == $past(rx_ctrl_frame_in))
    else $error("control frame not forwarded");

  // ----------------------------------------
  // assertions: pause header
  // ----------------------------------------
  a_global_hdr: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !tx_prio_sel_in |=> pause_hdr_out == $past(cfg_reg.global_hdr))
    else $error("global pause header wrong");
  a_prio_hdr: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && tx_prio_sel_in |=> pause_hdr_out == $past(cfg_reg.prio_hdr))
    else $error("priority pause header wrong");
  a_src_split: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && tx_prio_sel_in |=> pause_hdr_out.src_addr == $past(cfg_reg.prio_hdr.src_addr))
    else $error("priority source address wrong");
  a_global_src: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !tx_prio_sel_in |=> pause_hdr_out.src_addr == $past(cfg_reg.global_hdr.src_addr))
    else $error("global source address wrong");

  // ----------------------------------------
  // assertions: timestamp path
  // ----------------------------------------
  a_step_gate: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    single_step_ts_valid_out |-> $past(cfg_reg.single_step_ts_en))
    else $error("single-step while disabled");
  a_step_off: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !cfg_reg.single_step_ts_en |=> !single_step_ts_valid_out)
    else $error("single-step stamp while disabled");
  a_step_pulse: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && step_fire |=> single_step_ts_valid_out)
    else $error("single-step stamp missing");
  a_step_clear: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !tx_ptp_pkt_in |=> !single_step_ts_valid_out)
    else $error("single-step stamp without packet");
  // checked against the raw timer, not the adder output
  a_lat_offset: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && step_fire |=> single_step_ts_out
    == $past(timer_in) + {69'h0, $past(cfg_reg.ts_latency_adjust)})
    else $error("latency adjust offset wrong");
  a_step_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !step_fire |=> $stable(single_step_ts_out))
    else $error("stamp moved without packet");
  a_corr_add: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && corr_fire
    |=> corr_update_out && corr_field_out == $past(corr_field_in) + $past(stamp[63:0]))
    else $error("correction field not updated");
  a_corr_off: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !cfg_reg.transparent_clk_mode |=> !corr_update_out)
    else $error("correction update while disabled");
  a_corr_clear: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !tx_ptp_pkt_in |=> !corr_update_out)
    else $error("correction update without packet");
  a_corr_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && !corr_fire |=> $stable(corr_field_out))
    else $error("correction field moved without packet");

  // ----------------------------------------
  // assertions: configuration and enable
  // ----------------------------------------
  a_cfg_stable: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && cfg_reg != $past(cfg_reg) |-> $past(cfg_in) == $past(cfg_seen_reg))
    else $error("unsettled configuration applied");
  a_cfg_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ce_in && cfg_live_reg && cfg_seen_reg != cfg_in |=> $stable(cfg_reg))
    else $error("changing configuration applied");
  a_cfg_first: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !cfg_live_reg |=> $stable(cfg_reg))
    else $error("configuration applied on first sample");
  a_cfg_frozen: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !ce_in |=> $stable(cfg_reg))
    else $error("configuration moved while clock enable low");
  a_out_frozen: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !ce_in |=> $stable(pause_hdr_out) && $stable(pause_ack_used_out)
    && $stable(single_step_ts_valid_out) && $stable(corr_update_out))
    else $error("outputs moved while clock enable low");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_step: cover property (@(posedge mclk_in) single_step_ts_valid_out);
  c_corr: cover property (@(posedge mclk_in) corr_update_out);
  c_prio: cover property (@(posedge mclk_in) ce_in && tx_prio_sel_in);
  c_fwd: cover property (@(posedge mclk_in) rx_ctrl_pass_out);
  c_ack_off: cover property (@(posedge mclk_in) ce_in && !cfg_reg.pause_ack_wait);
endmodule : pptc_config
`default_nettype wire

//--- pptc_user_model.sv
`timescale 1ns/10ps
`default_nettype none
module pptc_user_model (
  // clock
  input wire logic mclk_in,
  // timing packet towards the block
  output logic ptp_out,
  output logic [79:0] timer_out,
  output logic [63:0] corr_out
);
  initial begin
    ptp_out = 1'b0;
    timer_out = '0;
    corr_out = '0;
  end
  task automatic send(input logic [63:0] orig, rx_ts, input logic [79:0] t);
    @(posedge mclk_in) #1;
    ptp_out = 1'b1;
    timer_out = t;
    corr_out = orig - rx_ts;
    @(posedge mclk_in) #1;
    ptp_out = 1'b0;
    // released lines show garbage, not the old value
    timer_out = ~timer_out;
    corr_out = ~corr_out;
  endtask : send
endmodule : pptc_user_model
`default_nettype wire

//--- pptc_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pptc_config_tb;
  logic mclk = 1'b0, resetn = 1'b0, ce = 1'b1, ctrl = 1'b0, prio = 1'b0;
  logic ptp, pass, ts_v, corr_up;
  pptc_pkg::pptc_cfg_t cfg = pptc_pkg::DEF_CFG;
  pptc_pkg::pptc_pause_hdr_t hdr;
  logic [8:0] ack = 9'h000, ack_used;
  logic [79:0] timer, ts;
  logic [63:0] corr, corr_o;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  initial forever #2.5 mclk = ~mclk;
  pptc_config pptc_config_i (.mclk_in(mclk), .resetn_in(resetn), .ce_in(ce), .cfg_in(cfg),
    .pause_ack_bus_in(ack), .rx_ctrl_frame_in(ctrl), .pause_ack_used_out(ack_used),
    .rx_ctrl_pass_out(pass), .tx_prio_sel_in(prio), .pause_hdr_out(hdr),
    .tx_ptp_pkt_in(ptp), .timer_in(timer), .corr_field_in(corr),
    .single_step_ts_out(ts), .single_step_ts_valid_out(ts_v),
    .corr_field_out(corr_o), .corr_update_out(corr_up));
  pptc_user_model pptc_user_model_i (.mclk_in(mclk), .ptp_out(ptp), .timer_out(timer),
    .corr_out(corr));
  task automatic check(input logic [127:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic step();
    @(posedge mclk) #1;
  endtask : step
  // restart changes the settings while reset is held
  task automatic restart(input pptc_pkg::pptc_cfg_t c);
    step();
    resetn = 1'b0;
    cfg = c;
    repeat (10) step();
    resetn = 1'b1;
    repeat (4) step();
  endtask : restart
  // -------------------------
  // scenarios
  // -------------------------
  task automatic defaults_run();
    restart(pptc_pkg::DEF_CFG);
    ack = 9'h1a5;
    ctrl = 1'b1;
    step();
    check(ack_used, 9'h1a5);
    check(pass, 1'b0);
    check(hdr, {48'h0180_c200_0001, 48'h0, 16'h8808, 16'h0001});
    prio = 1'b1;
    step();
    check(hdr, {48'h0180_c200_0001, 48'h0, 16'h8808, 16'h0101});
    pptc_user_model_i.send(64'h0000_0000_0000_1000, 64'h0, 80'h0000_0000_0000_0000_0400);
    check(ts_v, 1'b0);
    check(corr_up, 1'b0);
  endtask : defaults_run
  task automatic custom_run();
    pptc_pkg::pptc_cfg_t c;
    logic [79:0] t, e;
    c = pptc_pkg::DEF_CFG;
    c.pause_ack_wait = 1'b0;
    c.forward_ctrl_frames = 1'b1;
    c.global_hdr = {48'h0200_0000_00aa, 48'h0a0b_0c0d_0e0f, 16'h88f7, 16'h0003};
    c.prio_hdr = {48'h0300_0000_00bb, 48'h1111_2222_3333, 16'h8809, 16'h0202};
    c.single_step_ts_en = 1'b1;
    c.transparent_clk_mode = 1'b1;
    c.ts_latency_adjust = 11'h322;
    t = 80'h0000_0001_0000_0000_0ff8;
    e = t + 80'h322;
    restart(c);
    prio = 1'b0;
    step();
    check(ack_used, 9'h1ff);
    check(pass, 1'b1);
    check(hdr, c.global_hdr);
    prio = 1'b1;
    step();
    check(hdr, c.prio_hdr);
    pptc_user_model_i.send(64'h0000_0000_0009_0000, 64'h0000_0000_0000_5000, t);
    check({ts_v, corr_up}, 2'b11);
    check(ts, e);
    check(corr_o, 64'h0008_b000 + e[63:0]);
    step();
    check({ts_v, corr_up}, 2'b00);
    check(ts, e);
    // a one-cycle glitch on a setting must never be applied
    cfg.forward_ctrl_frames = 1'b0;
    step();
    check(pass, 1'b1);
    cfg.forward_ctrl_frames = 1'b1;
    repeat (4) begin
      step();
      check(pass, 1'b1);
    end
  endtask : custom_run
  // ce low must hold every output, strobes included
  task automatic freeze_run();
    ce = 1'b0;
    prio = 1'b0;
    ctrl = 1'b0;
    pptc_user_model_i.send(64'h0000_0000_0000_0100, 64'h0, 80'h0000_0000_0000_0000_0200);
    check({ts_v, corr_up, pass}, 3'b001);
    check(hdr, cfg.prio_hdr);
    check(ts, 80'h0000_0001_0000_0000_131a);
    ce = 1'b1;
    step();
    check(hdr, cfg.global_hdr);
    check(pass, 1'b0);
  endtask : freeze_run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    defaults_run();
    custom_run();
    freeze_run();
    print_verdict();
  end
endmodule : pptc_config_tb
`default_nettype wire
